// File: rtl/accumulator_abs_add_alu.sv
// Purpose: Accumulator slice running magnitude and shifted add
// Assumes: Sequencer and data memory share core_clk
// Notes: One request at a time, instr_ready high only when idle
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`include "alu_params.svh"
module accumulator_abs_add_alu
    import alu_pkg::*;
#(
    parameter int TAC_PS = `ZERO_WAIT_WINDOW_PS,
    parameter int CRYSTAL_PERIOD_PS = `CRYSTAL_PERIOD_PS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic instr_valid,
    input wire instr_req_t instr,
    output logic instr_ready,
    output logic data_req,
    output logic [7:0] data_addr,
    input wire logic data_valid,
    input wire logic [15:0] data_word,
    output logic pc_inc,
    output logic instr_done,
    output logic irq
);
    // [RULE_11] Machine period from crystal
    localparam int TP_PS = `CRYSTALS_PER_MACHINE * CRYSTAL_PERIOD_PS;

    state_t state_reg;
    op_t op_reg;
    op_t op_dec;
    mode_t mode_reg;
    logic [15:0] word_reg;
    logic ext_data_reg;
    logic [7:0] iter_reg;
    logic [3:0] wait_reg;
    logic [15:0] opnd_reg;
    logic [15:0] cycles_reg;
    logic [15:0] last_cycles_reg;
    logic [31:0] acc_reg;
    logic carry_reg;
    logic wrap_reg;
    logic [`INT_WIDTH-1:0] int_status_reg;
    logic [`INT_WIDTH-1:0] int_mask_reg;
    logic [`INT_WIDTH-1:0] int_set;
    logic [15:0] tmem_reg [3];
    logic [3:0] waits [3];
    logic [3:0] p_waits;
    logic [3:0] d_waits;
    logic [3:0] i_waits;
    logic accept;
    logic exec;
    logic last_iter;
    logic [31:0] mag_result;
    logic mag_wrap;
    logic [31:0] addend;
    logic [32:0] sum;
    logic [31:0] add_result;
    logic add_wrap;
    logic [31:0] exec_result;
    logic exec_wrap;
    logic exec_carry;
    logic wr_ctrl;
    logic wr_acc;
    logic wr_flags;
    logic wr_int_status;
    logic wr_int_mask;

    // Wait-state counts for program, data and I/O
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_waits
            // Wait count per space
            wait_state_calc #(
                .TAC_PS(TAC_PS),
                .TP_PS(TP_PS),
                .MAX_WAITS(`MAX_WAITS)
            ) u_wait (
                .tmem_ps(tmem_reg[g]),
                .waits(waits[g])
            );
        end
    endgenerate

    // [RULE_09] Program wait count
    assign p_waits = waits[0];
    // [RULE_10] Data and I/O wait counts
    assign d_waits = waits[1];
    assign i_waits = waits[2];

    // Opcode decode
    always_comb
    begin
        op_dec = OP_NONE;
        // [RULE_13] Magnitude opcode
        if (instr.word == `OPC_MAGNITUDE)
        begin
            op_dec = OP_MAG;
        end
        // [RULE_14] Shifted add opcode field
        else if (instr.word[15:12] == `OPC_ADD_TOP)
        begin
            op_dec = OP_ADD;
        end
    end

    assign instr_ready = (state_reg == S_IDLE);
    assign accept = ce && instr_valid && instr_ready;
    assign exec = ce && (state_reg == S_EXEC);
    assign last_iter = (iter_reg <= 8'h01);
    assign data_req = (state_reg == S_DREQ);
    // [RULE_14] Direct address or indirect control out
    assign data_addr = word_reg[7:0];

    // Magnitude datapath
    always_comb
    begin
        mag_result = acc_reg;
        mag_wrap = 1'b0;
        // [RULE_02] Most negative special case
        if (acc_reg == `ACC_MOST_NEG)
        begin
            mag_result = mode_reg.saturate_mode_bit ? `ACC_MOST_POS : `ACC_MOST_NEG;
            // [RULE_03] Wrap flag in either mode
            mag_wrap = 1'b1;
        end
        // [RULE_01] Negate negative value
        else if (acc_reg[31])
        begin
            mag_result = 32'(~acc_reg + 32'h0000_0001);
        end
    end

    // Shifted add datapath
    always_comb
    begin
        // [RULE_06] Sign or zero extension
        if (mode_reg.sign_ext_mode_bit)
        begin
            addend = {{16{opnd_reg[15]}}, opnd_reg};
        end
        else
        begin
            addend = {16'h0000, opnd_reg};
        end
        // [RULE_07] Shift count 0 to 15
        addend = addend << word_reg[11:8];
        sum = {1'b0, acc_reg} + {1'b0, addend};
        add_wrap = (acc_reg[31] == addend[31]) && (sum[31] != acc_reg[31]);
        add_result = sum[31:0];
        // [RULE_08] Saturate on overflow
        if (add_wrap && mode_reg.saturate_mode_bit)
        begin
            add_result = acc_reg[31] ? `ACC_MOST_NEG : `ACC_MOST_POS;
        end
    end

    always_comb
    begin
        exec_result = add_result;
        exec_wrap = add_wrap;
        // [RULE_08] Carry from the add
        exec_carry = sum[32];
        if (op_reg == OP_MAG)
        begin
            exec_result = mag_result;
            exec_wrap = mag_wrap;
            // [RULE_04] Carry always cleared
            exec_carry = 1'b0;
        end
    end

    // Sequencing of fetch waits, data fetch and execution
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= S_IDLE;
            op_reg <= OP_NONE;
            word_reg <= 16'h0000;
            ext_data_reg <= 1'b0;
            iter_reg <= 8'h00;
            wait_reg <= 4'h0;
            opnd_reg <= 16'h0000;
        end
        else if (ce)
        begin
            unique case (state_reg)
                S_IDLE:
                begin
                    if (instr_valid && op_dec != OP_NONE)
                    begin
                        op_reg <= op_dec;
                        word_reg <= instr.word;
                        ext_data_reg <= instr.ext_data;
                        // [RULE_12] Execute n times
                        iter_reg <= instr.rpt_n;
                        // [RULE_05] Program waits when fetched outside
                        if (instr.ext_prog && p_waits != 4'h0)
                        begin
                            wait_reg <= p_waits;
                            state_reg <= S_PWAIT;
                        end
                        else
                        begin
                            state_reg <= (op_dec == OP_ADD) ? S_DREQ : S_EXEC;
                        end
                    end
                end
                S_PWAIT:
                begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1)
                    begin
                        state_reg <= (op_reg == OP_ADD) ? S_DREQ : S_EXEC;
                    end
                end
                S_DREQ:
                begin
                    // [RULE_10] Data waits when operand is outside
                    wait_reg <= ext_data_reg ? d_waits : 4'h0;
                    state_reg <= S_DWAIT;
                end
                S_DWAIT:
                begin
                    if (wait_reg != 4'h0)
                    begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                    else if (data_valid)
                    begin
                        opnd_reg <= data_word;
                        state_reg <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    iter_reg <= iter_reg - 8'h01;
                    // [RULE_12] Repeat until n done
                    if (last_iter)
                    begin
                        state_reg <= S_IDLE;
                    end
                    else if (op_reg == OP_ADD)
                    begin
                        state_reg <= S_DREQ;
                    end
                end
            endcase
        end
    end

    // Cycle count of each instruction
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cycles_reg <= 16'h0000;
            last_cycles_reg <= 16'h0000;
        end
        else if (ce)
        begin
            if (accept)
            begin
                cycles_reg <= 16'h0000;
            end
            else if (state_reg != S_IDLE)
            begin
                cycles_reg <= cycles_reg + 16'h0001;
            end
            // [RULE_05] Cycles of the finished instruction
            if (exec && last_iter)
            begin
                last_cycles_reg <= cycles_reg + 16'h0001;
            end
        end
    end

    // Completion pulses
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pc_inc <= 1'b0;
            instr_done <= 1'b0;
        end
        else if (ce)
        begin
            // [RULE_13] Program counter advances by one
            pc_inc <= exec && last_iter;
            instr_done <= (exec && last_iter) || (accept && op_dec == OP_NONE);
        end
    end

    assign wr_ctrl = ce && reg_wr && (reg_addr == `OFS_CTRL);
    assign wr_acc = ce && reg_wr && (reg_addr == `OFS_ACC);
    assign wr_flags = ce && reg_wr && (reg_addr == `OFS_FLAGS);
    assign wr_int_status = ce && reg_wr && (reg_addr == `OFS_INT_STATUS);
    assign wr_int_mask = ce && reg_wr && (reg_addr == `OFS_INT_MASK);

    // Mode bits
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg <= `RST_CTRL;
        end
        else if (wr_ctrl)
        begin
            mode_reg.saturate_mode_bit <= reg_wdata[`CTRL_SAT_BIT];
            mode_reg.sign_ext_mode_bit <= reg_wdata[`CTRL_SXM_BIT];
        end
    end

    // Accumulator, execution wins over a software write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= `RST_ACC;
        end
        else if (exec)
        begin
            acc_reg <= exec_result;
        end
        else if (wr_acc)
        begin
            acc_reg <= reg_wdata;
        end
    end

    // Carry and sticky wrap flag
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            carry_reg <= 1'b0;
            wrap_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (exec)
            begin
                carry_reg <= exec_carry;
            end
            else if (wr_flags)
            begin
                carry_reg <= reg_wdata[`FLAG_CARRY_BIT];
            end
            // [RULE_03] Set wins over clear
            wrap_reg <= (wrap_reg && !(wr_flags && reg_wdata[`FLAG_WRAP_BIT])) || (exec && exec_wrap);
        end
    end

    // Interrupt events
    always_comb
    begin
        int_set = '0;
        int_set[`INT_WRAP_BIT] = exec && exec_wrap;
        int_set[`INT_DONE_BIT] = exec && last_iter;
        int_set[`INT_ILLEGAL_BIT] = accept && (op_dec == OP_NONE);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            int_status_reg <= '0;
        end
        else if (ce)
        begin
            if (wr_int_status)
            begin
                int_status_reg <= (int_status_reg & ~reg_wdata[`INT_WIDTH-1:0]) | int_set;
            end
            else
            begin
                int_status_reg <= int_status_reg | int_set;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            int_mask_reg <= `RST_INT_MASK;
        end
        else if (wr_int_mask)
        begin
            int_mask_reg <= reg_wdata[`INT_WIDTH-1:0];
        end
    end

    assign irq = |(int_status_reg & int_mask_reg);

    // Memory access times, one per space
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tmem_reg[0] <= `RST_TMEM;
            tmem_reg[1] <= `RST_TMEM;
            tmem_reg[2] <= `RST_TMEM;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == `OFS_TMEM_PROG)
            begin
                tmem_reg[0] <= reg_wdata[15:0];
            end
            if (reg_addr == `OFS_TMEM_DATA)
            begin
                tmem_reg[1] <= reg_wdata[15:0];
            end
            if (reg_addr == `OFS_TMEM_IO)
            begin
                tmem_reg[2] <= reg_wdata[15:0];
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `OFS_CTRL: reg_rdata <= {30'h0, mode_reg};
                    `OFS_ACC: reg_rdata <= acc_reg;
                    `OFS_FLAGS: reg_rdata <= {30'h0, carry_reg, wrap_reg};
                    `OFS_INT_STATUS: reg_rdata <= {29'h0, int_status_reg};
                    `OFS_INT_MASK: reg_rdata <= {29'h0, int_mask_reg};
                    `OFS_TMEM_PROG: reg_rdata <= {16'h0000, tmem_reg[0]};
                    `OFS_TMEM_DATA: reg_rdata <= {16'h0000, tmem_reg[1]};
                    `OFS_TMEM_IO: reg_rdata <= {16'h0000, tmem_reg[2]};
                    `OFS_WAIT_STATES: reg_rdata <= {20'h0, i_waits, d_waits, p_waits};
                    `OFS_LAST_CYCLES: reg_rdata <= {16'h0000, last_cycles_reg};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // accumulator_abs_add_alu

// File: shared/alu_params.svh
// Purpose: Constants for the accumulator magnitude / shifted-add slice
// Assumes: 32-bit register words, byte addresses on an 8-bit address port
// Notes: Times in picoseconds, counts derived from them
// Notes on behaviour
// [RULE_01] Magnitude keeps a non-negative accumulator and negates a negative one.
// [RULE_02] Magnitude of 8000_0000 stays 8000_0000, or gives 7FFF_FFFF when saturating.
// [RULE_03] Magnitude of 8000_0000 sets the wrap flag in both modes.
// [RULE_04] Magnitude always clears the carry.
// [RULE_05] Magnitude takes one cycle, plus program waits when fetched outside, n under repeat.
// [RULE_06] Shifted add shifts the data word left and adds it, sign or zero extended by mode.
// [RULE_07] The shift count runs from 0 to 15, zero when not given.
// [RULE_08] Shifted add updates wrap and carry and saturates or wraps by mode.
// [RULE_09] An outside program access waits the least p with access time within p periods plus window.
// [RULE_10] Outside data and I/O waits d and i follow the same rule.
// [RULE_11] The machine period used for waits is four crystal periods.
// [RULE_12] Under repeat the instruction runs n times and its cycles scale with n.
// [RULE_13] Magnitude is opcode CE1B and advances the program counter by one.
// [RULE_14] Shifted add has 0000 on top, shift in 11-8, indirect in 7, address in 6-0.
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define OFS_CTRL 8'h00
`define OFS_ACC 8'h04
`define OFS_FLAGS 8'h08
`define OFS_INT_STATUS 8'h0C
`define OFS_INT_MASK 8'h10
`define OFS_TMEM_PROG 8'h14
`define OFS_TMEM_DATA 8'h18
`define OFS_TMEM_IO 8'h1C
`define OFS_WAIT_STATES 8'h20
`define OFS_LAST_CYCLES 8'h24

`define CTRL_SAT_BIT 0
`define CTRL_SXM_BIT 1
`define FLAG_WRAP_BIT 0
`define FLAG_CARRY_BIT 1
`define INT_WRAP_BIT 0
`define INT_DONE_BIT 1
`define INT_ILLEGAL_BIT 2
`define INT_WIDTH 3

`define RST_CTRL 2'h0
`define RST_ACC 32'h0000_0000
`define RST_TMEM 16'h0000
`define RST_INT_MASK 3'h0

`define OPC_MAGNITUDE 16'hCE1B
`define OPC_ADD_TOP 4'h0
`define ACC_MOST_NEG 32'h8000_0000
`define ACC_MOST_POS 32'h7FFF_FFFF

`define CRYSTAL_PERIOD_PS 1000
`define CRYSTALS_PER_MACHINE 4
`define MACHINE_PERIOD_PS (`CRYSTALS_PER_MACHINE * `CRYSTAL_PERIOD_PS)
`define ZERO_WAIT_WINDOW_PS 1000
`define MAX_WAITS 15

`endif

// File: shared/alu_pkg.sv
// Purpose: Types for the accumulator magnitude / shifted-add slice
// Assumes: Constants come from alu_params.svh
// Notes: Carrier structs for sequencer requests
package alu_pkg;

    typedef struct packed {
        logic ext_prog;
        logic ext_data;
        logic [7:0] rpt_n;
        logic [15:0] word;
    } instr_req_t;

    typedef struct packed {
        logic sign_ext_mode_bit;
        logic saturate_mode_bit;
    } mode_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_MAG,
        OP_ADD
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PWAIT,
        S_DREQ,
        S_DWAIT,
        S_EXEC
    } state_t;

endpackage

// File: rtl/wait_state_calc.sv
// Purpose: Wait-state count from a memory access time
// Assumes: Times in picoseconds, access time is static between uses
// Notes: Result saturates at the largest count
`timescale 1ns/10ps
`include "alu_params.svh"
module wait_state_calc #(
    parameter int TAC_PS = `ZERO_WAIT_WINDOW_PS,
    parameter int TP_PS = `MACHINE_PERIOD_PS,
    parameter int MAX_WAITS = `MAX_WAITS
) (
    input wire logic [15:0] tmem_ps,
    output logic [3:0] waits
);
    // Least k with access time within k periods plus window
    always_comb
    begin
        waits = 4'(MAX_WAITS);
        for (int k = MAX_WAITS; k >= 0; k--)
        begin
            if ({16'h0000, tmem_ps} <= 32'(k * TP_PS + TAC_PS))
            begin
                waits = 4'(k);
            end
        end
    end
endmodule // wait_state_calc

// File: sim/accumulator_abs_add_alu_monitor.sv
// Purpose: Port checks for the accumulator slice
// Assumes: ce held high while checks matter
// Notes: Bound to every instance of the slice
`timescale 1ns/10ps
`include "alu_params.svh"
module accumulator_abs_add_alu_monitor
    import alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire instr_req_t instr,
    input wire logic instr_ready,
    input wire logic data_req,
    input wire logic [7:0] data_addr,
    input wire logic pc_inc,
    input wire logic instr_done
);
    logic take;
    logic is_mag;
    logic is_add;
    assign take = instr_valid && instr_ready && ce;
    assign is_mag = instr.word == `OPC_MAGNITUDE;
    assign is_add = instr.word[15:12] == `OPC_ADD_TOP;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_mag_single: assert property (
        take && is_mag && !instr.ext_prog && instr.rpt_n <= 8'h01
        |-> ##1 !instr_ready ##1 (pc_inc && instr_done && instr_ready))
        else $error("magnitude did not finish in two cycles");
    chk_mag_repeat: assert property (
        take && is_mag && !instr.ext_prog && instr.rpt_n == 8'h03
        |-> ##1 (!pc_inc) [*3] ##1 pc_inc)
        else $error("repeated magnitude took the wrong count");
    chk_illegal_op: assert property (
        take && !is_mag && !is_add |=> instr_done && !pc_inc && instr_ready)
        else $error("illegal opcode not refused");
    chk_add_fetch: assert property (
        take && is_add && !instr.ext_prog |=> data_req && data_addr == $past(instr.word[7:0]))
        else $error("shifted add operand fetch wrong");
    chk_pc_pair: assert property (
        pc_inc |-> instr_done && instr_ready)
        else $error("pc step without completion");
    chk_dreq_pulse: assert property (
        data_req |=> !data_req)
        else $error("operand request longer than one cycle");
    chk_idle_no_req: assert property (
        instr_ready |-> !data_req)
        else $error("operand request while idle");
    chk_mag_no_fetch: assert property (
        take && is_mag |-> ##1 (!data_req) [*2])
        else $error("magnitude fetched an operand");
endmodule // accumulator_abs_add_alu_monitor

bind accumulator_abs_add_alu accumulator_abs_add_alu_monitor mon (
    .core_clk(core_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .data_req(data_req), .data_addr(data_addr),
    .pc_inc(pc_inc), .instr_done(instr_done)
);

// File: sim/data_mem_model.sv
// Purpose: Data memory answering operand requests
// Assumes: One request outstanding at a time
// Notes: Word lines invert while not valid
`timescale 1ns/10ps
module data_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic data_req,
    input wire logic [7:0] data_addr,
    input wire logic [3:0] dly,
    output logic data_valid,
    output logic [15:0] data_word
);
    logic [15:0] mem [128];
    logic pend;
    logic [3:0] cnt;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pend <= 1'h0;
            cnt <= 4'h0;
            data_valid <= 1'h0;
            data_word <= 16'h0000;
        end
        else
        begin
            data_valid <= 1'h0;
            data_word <= ~data_word;
            if ((data_req && dly == 4'h0) || (pend && cnt == 4'h0))
            begin
                data_valid <= 1'h1;
                data_word <= mem[data_addr[6:0]];
                pend <= 1'h0;
            end
            else if (data_req)
            begin
                pend <= 1'h1;
                cnt <= dly - 4'h1;
            end
            else if (pend)
                cnt <= cnt - 4'h1;
        end
    end
endmodule // data_mem_model

// File: sim/accumulator_abs_add_alu_bench.sv
// Purpose: Self-checking bench for the accumulator slice
// Assumes: ce held high except while test_irq drops one write, data memory model on the operand port
// Notes: Cycle counts taken from the accepting edge
`timescale 1ns/10ps
`include "alu_params.svh"
module accumulator_abs_add_alu_bench
    import alu_pkg::*;
;
    logic core_clk = 1'h0, rst = 1'h1, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic instr_valid = 1'h0;
    instr_req_t instr = '0;
    logic [3:0] dly = 4'h0;
    logic [31:0] reg_rdata, rv;
    logic [7:0] data_addr;
    logic [15:0] data_word;
    logic instr_ready, data_req, data_valid, pc_inc, instr_done, irq;
    int n_errors = 0;
    int total_checks = 0;
    int cyc;
    accumulator_abs_add_alu DUT (.core_clk(core_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .data_req(data_req), .data_addr(data_addr),
        .data_valid(data_valid), .data_word(data_word), .pc_inc(pc_inc),
        .instr_done(instr_done), .irq(irq));
    data_mem_model mem_model (.core_clk(core_clk), .rst(rst), .data_req(data_req),
        .data_addr(data_addr), .dly(dly), .data_valid(data_valid), .data_word(data_word));
    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 cmp(reg_rdata, e);
    endtask
    task automatic prep(input logic [1:0] c, input logic [31:0] acc, input logic cy);
        wr(`OFS_CTRL, {30'h0, c});
        wr(`OFS_ACC, acc);
        wr(`OFS_FLAGS, {30'h0, cy, 1'h1});
    endtask
    task automatic run(input logic xp, input logic xd, input logic [7:0] n,
        input logic [15:0] w);
        @(posedge core_clk);
        instr_valid <= 1'h1;
        instr <= '{xp, xd, n, w};
        @(posedge core_clk);
        instr_valid <= 1'h0;
        for (cyc = 0; cyc < 300; cyc++)
        begin
            #1;
            if (instr_done === 1'h1)
                break;
            @(posedge core_clk);
        end
    endtask
    function automatic logic [33:0] add_model(input logic [31:0] a, input logic [15:0] w,
        input logic [3:0] s, input logic [1:0] c);
        logic [31:0] op;
        logic [32:0] sum;
        logic ov;
        op = (c[1] ? {{16{w[15]}}, w} : {16'h0000, w}) << s;
        sum = {1'h0, a} + {1'h0, op};
        ov = (a[31] == op[31]) && (sum[31] != a[31]);
        if (ov && c[0])
            sum[31:0] = a[31] ? `ACC_MOST_NEG : `ACC_MOST_POS;
        return {sum[32], ov, sum[31:0]};
    endfunction
    task automatic test_reset;
        wr(8'h40, 32'hFFFF_FFFF);
        for (int a = 0; a < 68; a += 4)
            rc(8'(a), 32'h0000_0000);
    endtask
    task automatic test_mag;
        logic [31:0] ac [4] = '{32'h0000_1234, 32'hFFFF_FFFF, 32'h8000_0000, 32'h8000_0000};
        logic [31:0] ex [4] = '{32'h0000_1234, 32'h0000_0001, 32'h8000_0000, 32'h7FFF_FFFF};
        for (int k = 0; k < 4; k++)
        begin
            prep(2'(k / 3), ac[k], 1'h1);
            run(1'h0, 1'h0, 8'h01, `OPC_MAGNITUDE);
            cmp(pc_inc, 1'h1);
            cmp(cyc, 1);
            rc(`OFS_ACC, ex[k]);
            rc(`OFS_FLAGS, k / 2);
        end
    endtask
    task automatic test_add;
        logic [31:0] ac [6] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0010,
            32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'hFFFF_FFFF};
        logic [15:0] w [6] = '{16'h8001, 16'h8001, 16'h8001, 16'h0001, 16'h0001, 16'h0001};
        logic [3:0] s [6] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0};
        logic [1:0] c [6] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
        logic [33:0] r;
        for (int k = 0; k < 6; k++)
        begin
            mem_model.mem[7'h55] = w[k];
            r = add_model(ac[k], w[k], s[k], c[k]);
            prep(c[k], ac[k], 1'h0);
            run(1'h0, 1'h0, 8'h01, {4'h0, s[k], 8'hD5});
            cmp(pc_inc, 1'h1);
            rc(`OFS_ACC, r[31:0]);
            rc(`OFS_FLAGS, {30'h0, r[33:32]});
        end
    endtask
    task automatic test_waits;
        int t [5] = '{1000, 1001, 5000, 5001, 65535};
        int p [5] = '{0, 1, 1, 2, 15};
        for (int k = 0; k < 5; k++)
        begin
            wr(`OFS_TMEM_PROG, t[k]);
            rc(`OFS_WAIT_STATES, p[k]);
        end
        wr(`OFS_TMEM_PROG, 32'h0000_2328);
        wr(`OFS_TMEM_DATA, 32'h0000_2328);
        wr(`OFS_TMEM_IO, 32'h0000_32C9);
        rc(`OFS_WAIT_STATES, 32'h0000_0422);
        for (int x = 0; x < 2; x++)
        begin
            prep(2'h0, 32'hFFFF_FFFB, 1'h0);
            run(x[0], 1'h0, 8'h03, `OPC_MAGNITUDE);
            cmp(cyc, 3 + 2 * x);
            rc(`OFS_LAST_CYCLES, 3 + 2 * x);
            rc(`OFS_ACC, 32'h0000_0005);
        end
        mem_model.mem[7'h12] = 16'h0100;
        dly = 4'h4;
        prep(2'h0, 32'h0000_0000, 1'h0);
        run(1'h0, 1'h1, 8'h03, 16'h0412);
        rc(`OFS_ACC, 32'h0000_3000);
        dly = 4'h0;
    endtask
    task automatic test_irq;
        wr(`OFS_INT_STATUS, 32'h0000_0007);
        wr(`OFS_INT_MASK, 32'h0000_0000);
        run(1'h0, 1'h0, 8'h01, 16'hF000);
        cmp(pc_inc, 1'h0);
        cmp(cyc, 0);
        cmp(irq, 1'h0);
        wr(`OFS_INT_MASK, 32'h0000_0004);
        #1 cmp(irq, 1'h1);
        wr(`OFS_INT_STATUS, 32'h0000_0004);
        #1 cmp(irq, 1'h0);
        // Clock enable low drops a write
        @(posedge core_clk);
        ce <= 1'h0;
        wr(`OFS_INT_MASK, 32'h0000_0000);
        ce <= 1'h1;
        rc(`OFS_INT_MASK, 32'h0000_0004);
    endtask
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    initial
    begin
        #100000;
        n_errors++;
        end_sim;
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        test_reset;
        test_mag;
        test_add;
        test_waits;
        test_irq;
        end_sim;
    end
endmodule // accumulator_abs_add_alu_bench
